/* core/wdlk_pkg.sv */
// package: constants and types for the watchdog lock and interrupt block
package wdlk_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] DOG_CONTROL_ADDR = 8'hc0;
	localparam logic [15:0] LOCK_KEY_ADDR = 16'h3ffa;
	localparam logic [7:0] FLASH_KEY_REG_ADDR = 8'hbb;
	localparam logic [15:0] PROT_TOP_ADDR = 16'h3fff;
	localparam logic [15:0] PROT_BOT_ADDR = 16'h3ffb;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int LOCK_BIT_POS = 7;
	localparam int PRE_MSB = 7;
	localparam int PRE_LSB = 4;
	localparam int IRQ_SEL_POS = 3;
	localparam int FLAG_POS = 2;
	localparam int ENABLE_POS = 1;
	localparam int UNLOCK_POS = 0;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [3:0] PRE_RESET = 4'h0;
	localparam logic ENABLE_RESET = 1'b1;
	localparam logic IRQ_SEL_RESET = 1'b0;
	localparam logic [7:0] LOCK_KEY_ERASED = 8'hff;
	localparam logic [7:0] LOCKED_KEY_DEFAULT = 8'h7f;
	// ----------------------------------------
	// timing: base period 15.6 ms at 100 MHz
	// ----------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int BASE_TIMEOUT_US = 15600;
	localparam int BASE_TIMEOUT_CYC = BASE_TIMEOUT_US * CLK_MHZ;
	localparam logic [3:0] PRE_MAX_TIMED = 4'h7;
	localparam logic [3:0] PRE_AUTO_RESET = 4'h8;
	localparam logic [3:0] PRE_DL_RESET = 4'h9;
	// ----------------------------------------
	// unlock sequence states
	// ----------------------------------------
	typedef enum logic [0:0] {
		WDLK_IDLE = 1'b0,
		WDLK_ARMED = 1'b1
	} wdlk_seq_t;
endpackage

/* core/wdlk_tick_if.sv */
// interface: timebase tick between core and prescaler
`timescale 1ns/10ps
interface wdlk_tick_if;
	logic clear;
	logic tick;
	modport src (input clear, output tick);
	modport dst (output clear, input tick);
endinterface

/* core/wdlk_tick.sv */
// module: base tick divider for the watchdog timeout
`timescale 1ns/10ps
module wdlk_tick #(
	parameter int BASE_CYC = wdlk_pkg::BASE_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// tick carrier
	wdlk_tick_if.src tk
);
	logic [31:0] cnt;
	logic [31:0] next_cnt;
	logic tick_q;
	logic next_tick_q;

	assign tk.tick = tick_q;

	// -------------------------------
	// divider: one pulse every BASE_CYC cycles
	// -------------------------------
	always_comb begin
		next_cnt = cnt + 32'h1;
		next_tick_q = 1'b0;
		if (tk.clear) begin
			next_cnt = 32'h0;
		end else if (cnt >= 32'(BASE_CYC - 1)) begin
			next_cnt = 32'h0;
			next_tick_q = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt <= 32'h0;
			tick_q <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick_q <= next_tick_q;
		end
	end
endmodule

/* core/wdlk_core.sv */
// module: watchdog lock, unlock sequence, timeout and flash key compare
//
// Operation
// - lock bit and seven-bit key share one byte
// - lock zero freezes enable one, irq select zero
// - timeout select stays writable while locked
// - locked default key reads 0x7f
// - protection written only on key match
// - write only directly after unlock bit set
// - timeout resets system unless irq selected
// - irq select sits at bit 3
// - watchdog irq high priority, ignores global enable
// - irq mode acts as periodic long timer
// - select codes: timed, auto reset, download reset
// - setting enable clears the counter
// - timeout flag kept over watchdog reset
`timescale 1ns/10ps
module wdlk_core #(
	parameter int BASE_CYC = wdlk_pkg::BASE_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// special register port from the core
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	// instruction boundary strobe
	input wire logic instr_done_i,
	// nonvolatile byte at the lock and key address
	input wire logic [7:0] nv_lock_key_i,
	// flash protection request
	input wire logic prot_req_i,
	input wire logic [7:0] prot_data_i,
	output logic prot_wr_o,
	output logic [15:0] prot_addr_o,
	output logic [7:0] prot_wdata_o,
	output logic prot_deny_o,
	// watchdog outputs
	output logic dog_reset_o,
	output logic dog_dl_reset_o,
	output logic dog_irq_o,
	output logic dog_irq_high_prio_o,
	output logic [7:0] flash_key_o
);
	wdlk_tick_if tk();

	wdlk_tick #(
		.BASE_CYC(BASE_CYC)
	) u_tick (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.tk(tk.src)
	);

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic watchdog_lock_bit;
	logic next_watchdog_lock_bit;
	logic [6:0] flash_key;
	logic [6:0] next_flash_key;
	logic [7:0] flash_key_reg;
	logic [7:0] next_flash_key_reg;
	logic [3:0] dog_pre;
	logic [3:0] next_dog_pre;
	logic dog_irq_select;
	logic next_dog_irq_select;
	logic dog_timeout_flag;
	logic next_dog_timeout_flag;
	logic dog_enable;
	logic next_dog_enable;
	wdlk_pkg::wdlk_seq_t seq;
	wdlk_pkg::wdlk_seq_t next_seq;
	logic [7:0] dog_cnt;
	logic [7:0] next_dog_cnt;
	logic loaded;
	logic next_loaded;
	logic rst_q;
	logic next_rst_q;
	logic dl_q;
	logic next_dl_q;
	logic irq_q;
	logic next_irq_q;
	logic prot_wr;
	logic next_prot_wr;
	logic [2:0] prot_idx;
	logic [2:0] next_prot_idx;
	logic [7:0] prot_dat;
	logic [7:0] next_prot_dat;
	logic deny_q;
	logic next_deny_q;
	logic [7:0] rdata;
	logic [7:0] next_rdata;

	// decode helpers
	logic ctl_hit;
	logic key_hit;
	logic expire;
	logic [7:0] stored_key;
	logic [7:0] limit;

	// timeout limit in base ticks: 1, 2, 4 ... 128
	function automatic logic [7:0] wdlk_limit(input logic [3:0] pre);
		wdlk_limit = 8'h1 << pre[2:0];
	endfunction

	assign ctl_hit = sfr_addr_i == wdlk_pkg::DOG_CONTROL_ADDR;
	assign key_hit = sfr_addr_i == wdlk_pkg::FLASH_KEY_REG_ADDR;
	assign stored_key = {watchdog_lock_bit, flash_key};
	assign limit = wdlk_limit(dog_pre);
	assign expire = dog_enable && tk.tick && (dog_pre <= wdlk_pkg::PRE_MAX_TIMED)
		&& (dog_cnt + 8'h1 >= limit);

	// ----------------------------------------
	// control register and unlock sequence
	// ----------------------------------------
	always_comb begin
		next_watchdog_lock_bit = watchdog_lock_bit;
		next_flash_key = flash_key;
		next_loaded = 1'b1;
		next_seq = seq;
		next_dog_pre = dog_pre;
		next_dog_irq_select = dog_irq_select;
		next_dog_enable = dog_enable;
		next_dog_timeout_flag = dog_timeout_flag;
		next_flash_key_reg = flash_key_reg;
		tk.clear = 1'b0;
		// lock byte latched once after reset release
		if (!loaded) begin
			next_watchdog_lock_bit = nv_lock_key_i[wdlk_pkg::LOCK_BIT_POS];
			next_flash_key = nv_lock_key_i[6:0];
		end
		if (sfr_wr_i && key_hit) begin
			next_flash_key_reg = sfr_wdata_i;
		end
		// one instruction window after the unlock bit is set
		if (seq == wdlk_pkg::WDLK_ARMED && instr_done_i) begin
			next_seq = wdlk_pkg::WDLK_IDLE;
		end
		if (sfr_wr_i && ctl_hit) begin
			if (seq == wdlk_pkg::WDLK_ARMED) begin
				next_seq = wdlk_pkg::WDLK_IDLE;
				next_dog_pre = sfr_wdata_i[wdlk_pkg::PRE_MSB:wdlk_pkg::PRE_LSB];
				if (!sfr_wdata_i[wdlk_pkg::FLAG_POS]) begin
					next_dog_timeout_flag = 1'b0;
				end
				if (watchdog_lock_bit) begin
					next_dog_irq_select = sfr_wdata_i[wdlk_pkg::IRQ_SEL_POS];
					next_dog_enable = sfr_wdata_i[wdlk_pkg::ENABLE_POS];
				end // locked: writes to these bits dropped
				if (sfr_wdata_i[wdlk_pkg::ENABLE_POS]) begin
					tk.clear = 1'b1;
				end
			end else if (sfr_wdata_i[wdlk_pkg::UNLOCK_POS]) begin
				next_seq = wdlk_pkg::WDLK_ARMED;
			end
		end
		// keep forced values whatever the write did
		if (loaded && !watchdog_lock_bit) begin
			next_dog_enable = 1'b1;
			next_dog_irq_select = 1'b0;
		end
		// set beats clear in the same cycle
		if (expire) begin
			next_dog_timeout_flag = 1'b1;
		end
	end

	// nrst_i is the external reset and clears the flag; a watchdog reset request
	// leaves this block running, so the flag survives it
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			watchdog_lock_bit <= 1'b0;
			flash_key <= 7'h7f;
			loaded <= 1'b0;
			seq <= wdlk_pkg::WDLK_IDLE;
			dog_pre <= wdlk_pkg::PRE_RESET;
			dog_irq_select <= wdlk_pkg::IRQ_SEL_RESET;
			dog_enable <= wdlk_pkg::ENABLE_RESET;
			dog_timeout_flag <= 1'b0;
			flash_key_reg <= 8'h00;
		end else begin
			watchdog_lock_bit <= next_watchdog_lock_bit;
			flash_key <= next_flash_key;
			loaded <= next_loaded;
			seq <= next_seq;
			dog_pre <= next_dog_pre;
			dog_irq_select <= next_dog_irq_select;
			dog_enable <= next_dog_enable;
			dog_timeout_flag <= next_dog_timeout_flag;
			flash_key_reg <= next_flash_key_reg;
		end
	end

	// ----------------------------------------
	// timeout counter and response
	// ----------------------------------------
	always_comb begin
		next_dog_cnt = dog_cnt;
		next_rst_q = 1'b0;
		next_dl_q = 1'b0;
		next_irq_q = 1'b0;
		if (tk.clear || !dog_enable) begin
			next_dog_cnt = 8'h0;
		end else if (expire) begin
			next_dog_cnt = 8'h0; // restart: periodic in irq mode
			if (dog_irq_select) begin
				next_irq_q = 1'b1;
			end else begin
				next_rst_q = 1'b1;
			end
		end else if (tk.tick) begin
			next_dog_cnt = dog_cnt + 8'h1;
		end
		// immediate reset codes
		if (dog_enable && dog_pre == wdlk_pkg::PRE_AUTO_RESET) begin
			next_rst_q = 1'b1;
		end
		if (dog_enable && dog_pre == wdlk_pkg::PRE_DL_RESET) begin
			next_dl_q = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dog_cnt <= 8'h0;
			rst_q <= 1'b0;
			dl_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			dog_cnt <= next_dog_cnt;
			rst_q <= next_rst_q;
			dl_q <= next_dl_q;
			irq_q <= next_irq_q;
		end
	end

	// ----------------------------------------
	// flash protection write, key checked first
	// ----------------------------------------
	always_comb begin
		next_prot_wr = 1'b0;
		next_prot_idx = prot_idx;
		next_prot_dat = prot_dat;
		next_deny_q = 1'b0;
		// step down only once the write has been shown, so the first byte hits the top
		if (prot_wr) begin
			next_prot_idx = (prot_idx == 3'h4) ? 3'h0 : prot_idx + 3'h1;
		end
		if (prot_req_i) begin
			if (flash_key_reg == stored_key) begin
				next_prot_wr = 1'b1;
				next_prot_dat = prot_data_i;
			end else begin
				next_deny_q = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prot_wr <= 1'b0;
			prot_idx <= 3'h0;
			prot_dat <= 8'h00;
			deny_q <= 1'b0;
		end else begin
			prot_wr <= next_prot_wr;
			prot_idx <= next_prot_idx;
			prot_dat <= next_prot_dat;
			deny_q <= next_deny_q;
		end
	end

	// ----------------------------------------
	// register read data
	// ----------------------------------------
	always_comb begin
		next_rdata = 8'h00;
		if (sfr_rd_i && ctl_hit) begin
			next_rdata = {dog_pre, dog_irq_select, dog_timeout_flag, dog_enable,
				seq == wdlk_pkg::WDLK_ARMED};
		end else if (sfr_rd_i && key_hit) begin
			next_rdata = flash_key_reg;
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata <= 8'h00;
		end else begin
			rdata <= next_rdata;
		end
	end

	// outputs
	assign sfr_rdata_o = rdata;
	assign prot_wr_o = prot_wr;
	assign prot_addr_o = wdlk_pkg::PROT_TOP_ADDR - {13'h0, prot_idx};
	assign prot_wdata_o = prot_dat;
	assign prot_deny_o = deny_q;
	assign dog_reset_o = rst_q;
	assign dog_dl_reset_o = dl_q;
	assign dog_irq_o = irq_q; // never gated by global enable
	assign dog_irq_high_prio_o = 1'b1;
	assign flash_key_o = stored_key;
endmodule

/* bench/wdlk_core_properties.sv */
// checker: concurrent properties on the watchdog core ports
`timescale 1ns/10ps
module wdlk_core_properties (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// register port and nonvolatile byte
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic [7:0] nv_lock_key_i,
	// protection
	input wire logic prot_req_i,
	input wire logic prot_wr_o,
	input wire logic [15:0] prot_addr_o,
	input wire logic prot_deny_o,
	// watchdog
	input wire logic dog_reset_o,
	input wire logic dog_dl_reset_o,
	input wire logic dog_irq_o,
	input wire logic dog_irq_high_prio_o,
	input wire logic [7:0] flash_key_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	prio_const_a: assert property (dog_irq_high_prio_o)
		else $error("watchdog irq priority not high");
	irq_spacing_a: assert property (dog_irq_o |=> !dog_irq_o [*8])
		else $error("watchdog irq repeats too soon");
	irq_not_reset_a: assert property (dog_irq_o |-> !dog_reset_o && !dog_dl_reset_o)
		else $error("irq and reset raised together");
	key_load_a: assert property ($rose(nrst_i) |=> flash_key_o == $past(nv_lock_key_i))
		else $error("lock and key byte not loaded");
	// lock cleared: reads show irq select 0 and enable 1
	lock_forced_a: assert property (sfr_rd_i && sfr_addr_i == wdlk_pkg::DOG_CONTROL_ADDR
		&& !flash_key_o[7] |=> !sfr_rdata_o[3] && sfr_rdata_o[1])
		else $error("locked config bits not forced");
	prot_answer_a: assert property (prot_req_i |=> prot_wr_o != prot_deny_o)
		else $error("protection request not answered once");
	prot_cause_a: assert property (prot_wr_o || prot_deny_o |-> $past(prot_req_i))
		else $error("protection answer without request");
	prot_range_a: assert property (prot_wr_o |-> prot_addr_o inside {[16'h3ffb:16'h3fff]})
		else $error("protection byte outside top of flash");
	// main scenarios reached
	cover property (dog_irq_o);
	cover property (dog_reset_o);
	cover property (prot_deny_o);
endmodule

bind wdlk_core wdlk_core_properties i_chk (.ref_clk_i, .nrst_i, .sfr_rd_i, .sfr_addr_i,
	.sfr_rdata_o, .nv_lock_key_i, .prot_req_i, .prot_wr_o, .prot_addr_o, .prot_deny_o,
	.dog_reset_o, .dog_dl_reset_o, .dog_irq_o, .dog_irq_high_prio_o, .flash_key_o);

/* bench/wdlk_cpu_model.sv */
// partner: processor core issuing register accesses and instruction ends
`timescale 1ns/10ps
module wdlk_cpu_model (
	// clock
	input wire logic ref_clk_i,
	// register port
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	input wire logic [7:0] rdata_i,
	// instruction boundary
	output logic done_o
);
	initial begin
		{wr_o, rd_o, done_o} = 3'b000;
		addr_o = 8'h00;
		wdata_o = 8'h00;
	end
	// one write instruction; released data lines go to the inverse
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= d;
		done_o <= 1'b1;
		@(posedge ref_clk_i);
		wr_o <= 1'b0;
		done_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask
	// one read instruction, data one cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		done_o <= 1'b1;
		@(posedge ref_clk_i);
		rd_o <= 1'b0;
		done_o <= 1'b0;
		addr_o <= ~a;
		#1 d = rdata_i;
	endtask
	// arm then write as two back-to-back instructions; no interrupt can
	// slip in, the model has none to take
	task automatic unl(input logic [7:0] d);
		wr(wdlk_pkg::DOG_CONTROL_ADDR, 8'h01);
		wr(wdlk_pkg::DOG_CONTROL_ADDR, d);
	endtask
	// an instruction that touches no register
	task automatic nop();
		@(posedge ref_clk_i);
		done_o <= 1'b1;
		@(posedge ref_clk_i);
		done_o <= 1'b0;
	endtask
endmodule

/* bench/wdlk_core_bench.sv */
// testbench: watchdog lock, unlock sequence, timeout and key compare
`timescale 1ns/10ps
module wdlk_core_bench;
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic sfr_wr, sfr_rd, done, prot_req;
	logic [7:0] addr, wdata, rdata, nv, pdata, fkey, pwd, r;
	logic [15:0] paddr;
	logic pwr, pdeny, drst, ddl, dirq, seen;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	localparam logic [7:0] CA = wdlk_pkg::DOG_CONTROL_ADDR;
	localparam logic [7:0] KA = wdlk_pkg::FLASH_KEY_REG_ADDR;
	always #5 ref_clk_i = ~ref_clk_i;
	wdlk_cpu_model i_cpu (.ref_clk_i, .wr_o(sfr_wr), .rd_o(sfr_rd), .addr_o(addr),
		.wdata_o(wdata), .rdata_i(rdata), .done_o(done));
	// short base tick keeps every timeout within a few thousand cycles
	wdlk_core #(.BASE_CYC(10)) i_dut (.ref_clk_i, .nrst_i, .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd),
		.sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .instr_done_i(done),
		.nv_lock_key_i(nv), .prot_req_i(prot_req), .prot_data_i(pdata), .prot_wr_o(pwr),
		.prot_addr_o(paddr), .prot_wdata_o(pwd), .prot_deny_o(pdeny), .dog_reset_o(drst),
		.dog_dl_reset_o(ddl), .dog_irq_o(dirq), .dog_irq_high_prio_o(), .flash_key_o(fkey));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// waits a bounded time for one output pulse or level
	task automatic wait_ev(input int sel, input int lim);
		logic [4:0] ev;
		#1;
		seen = 1'b0;
		for (int k = 0; k < lim && !seen; k++) begin
			ev = {pdeny, pwr, ddl, drst, dirq};
			seen = ev[sel];
			if (!seen) @(posedge ref_clk_i) #1;
		end
	endtask
	task automatic rst(input logic [7:0] v);
		nrst_i <= 1'b0;
		nv <= v;
		repeat (8) @(posedge ref_clk_i);
		#1 chk("key in reset", fkey, 8'h7f);
		@(posedge ref_clk_i) nrst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
	endtask
	task automatic prot(input logic [7:0] d);
		@(posedge ref_clk_i);
		prot_req <= 1'b1;
		pdata <= d;
		@(posedge ref_clk_i);
		prot_req <= 1'b0;
		pdata <= ~d;
	endtask
	// hang guard, over ten times the expected run length
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			final_report();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		prot_req <= 1'b0;
		pdata <= 8'h00;
		rst(8'hd5);
		chk("key loaded", fkey, 8'hd5);
		i_cpu.rd(CA, r); chk("control reset", r, 8'h02);
		i_cpu.wr(CA, 8'h18); i_cpu.rd(CA, r); chk("unarmed write", r, 8'h02);
		i_cpu.unl(8'h18); i_cpu.rd(CA, r); chk("armed write", r, 8'h18);
		i_cpu.wr(CA, 8'h01); i_cpu.nop(); i_cpu.wr(CA, 8'h1a);
		i_cpu.rd(CA, r); chk("stale arm", r, 8'h18);
		$display("test unlock done");
		i_cpu.unl(8'h0a);
		wait_ev(0, 300); chk("irq expiry", seen, 1);
		@(posedge ref_clk_i); wait_ev(0, 300); chk("irq repeat", seen, 1);
		i_cpu.rd(CA, r); chk("flag on expiry", r[2], 1);
		// rewrites of enable every few cycles must keep a 2-tick timeout from expiring
		i_cpu.unl(8'h18); i_cpu.unl(8'h1a);
		repeat (8) i_cpu.unl(8'h1e);
		i_cpu.rd(CA, r); chk("enable rewrite", r, 8'h1a);
		i_cpu.unl(8'h70); i_cpu.unl(8'h72);
		i_cpu.rd(CA, r); chk("flag cleared", r, 8'h72);
		wait_ev(1, 2000); chk("reset expiry", seen, 1);
		i_cpu.rd(CA, r); chk("flag kept", r[2], 1);
		for (int i = 0; i < 3; i++) begin
			i_cpu.unl({4'h8 + 4'(i), 4'h2});
			repeat (2) @(posedge ref_clk_i);
			#1 chk("code outputs", {drst, ddl}, {i == 0, i == 1});
		end
		$display("test timeout done");
		i_cpu.wr(KA, 8'hd5); prot(8'ha5); wait_ev(3, 5);
		chk("prot write", {seen, pwd, paddr}, {1'b1, 8'ha5, 16'h3fff});
		prot(8'h3c); wait_ev(3, 5);
		chk("prot next", {seen, pwd, paddr}, {1'b1, 8'h3c, 16'h3ffe});
		i_cpu.wr(KA, 8'h12); prot(8'h99); wait_ev(4, 5); chk("prot deny", seen, 1);
		$display("test protection done");
		@(posedge ref_clk_i);
		rst(8'h7f);
		chk("locked key", fkey, 8'h7f);
		i_cpu.rd(CA, r); chk("locked reset", r, 8'h02);
		i_cpu.unl(8'h38); i_cpu.rd(CA, r); chk("locked write", r, 8'h32);
		wait_ev(1, 300); chk("locked reset out", seen, 1);
		i_cpu.wr(KA, 8'h7f); prot(8'h11); wait_ev(3, 5); chk("locked key match", seen, 1);
		$display("test lock done");
		final_report();
	end
endmodule
